/* File: epp_defs.vh */
// constants for the phy-facing ethernet port
`ifndef EPP_DEFS_VH
`define EPP_DEFS_VH
`define EPP_MODE_MII        1'b0
`define EPP_MODE_RMII       1'b1
`define EPP_FIFO_W          9
`define EPP_FIFO_D          4
`define EPP_FIFO_AW         2
`define EPP_REF_MHZ         100
`define EPP_MDC_NS          400
`define EPP_MDC_HALF        ((`EPP_MDC_NS * `EPP_REF_MHZ) / 2000)
`define EPP_MDC_CW          8
`define EPP_MGMT_BITS       32
`define EPP_MGMT_CW         6
`endif

/* File: epp_fifo.v */
// small valid/ready fifo carrying bytes toward the transmit pins
`timescale 1ns/1ns
module epp_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,     // ref clock
    input  wire             rst_n,   // sync reset, active low
    input  wire [WIDTH-1:0] in_data, // write data
    input  wire             in_valid,// write request
    output wire             in_ready,// not full
    output wire [WIDTH-1:0] out_data,// head word
    output wire             out_valid,// not empty
    input  wire             out_ready // read acknowledge
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wp_q;
    reg [AW:0]      rp_q;
    wire            full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire            empty = (wp_q == rp_q);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp_q[AW-1:0]];
    always @(posedge clk) begin
        if (!rst_n) begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                mem[wp_q[AW-1:0]] <= in_data;
                wp_q <= wp_q + 1'b1;
            end
            if (out_ready && !empty)
                rp_q <= rp_q + 1'b1;
        end
    end
endmodule

/* File: epp_phy_model.sv */
// behavioural phy: link clocks and receive frames
`timescale 1ns/1ns
module epp_phy_model (
    input  wire        mode_rmii, // 1 selects rmii
    output logic       tx_clk,    // mii transmit clock
    output logic       rx_clk,    // receive or reference clock
    output logic [3:0] rxd,       // receive data
    output logic       rx_dv,     // valid or carrier/valid
    output logic       rx_er      // receive error
);
    logic       clk_q = 1'b0;
    logic [3:0] last_q = 4'h0;
    // free running, phase unrelated to the core clock
    initial begin #3; forever #40 clk_q = ~clk_q; end
    assign rx_clk = clk_q;
    assign tx_clk = mode_rmii ? 1'b1 : clk_q;
    initial begin rxd = 4'ha; rx_dv = 1'b0; rx_er = 1'b0; end
    task automatic put(input logic [3:0] v, input logic e);
        @(negedge clk_q);
        rxd <= v; rx_dv <= 1'b1; rx_er <= e; last_q <= v;
    endtask
    // error covers a whole byte, longer than one clock period
    task automatic send_byte(input logic [7:0] b, input logic e);
        if (mode_rmii) for (int i = 0; i < 8; i += 2) put({~b[i+:2], b[i+:2]}, e);
        else begin put(b[3:0], e); put(b[7:4], e); end
    endtask
    // whole bytes only, so carrier drops on a nibble boundary
    task automatic stop();
        @(negedge clk_q);
        rx_dv <= 1'b0; rx_er <= 1'b0; rxd <= ~last_q;
    endtask
endmodule

/* File: epp_port.v */
// mii/rmii pin interface of ethernet port 0, with management clock and data
// Notes on behaviour
// - mii mode drives a 4-bit transmit nibble, changed on tx clock falling edge.
// - transmit enable high while transmitting, aligned to tx clock.
// - rmii transmit uses dibits on data lines one and zero.
// - rmii enable rises with first preamble dibit, held until last dibit.
// - receive nibbles are taken only while receive valid is high.
// - rmii receive takes dibits from data lines one and zero.
// - falling receive valid marks frame end.
// - receive error during a frame flags that frame with crc error.
// - device drives management clock; data changes low, sampled on rising.
`timescale 1ns/1ns
`include "epp_defs.vh"
module epp_port (
    input  wire       REF_CLK,     // 100 mhz core clock
    input  wire       RESETN,      // sync reset, active low
    input  wire       MODE_RMII,   // 1 selects rmii
    input  wire [7:0] TX_DATA,     // byte to send, low nibble first
    input  wire       TX_LAST,     // marks final byte
    input  wire       TX_VALID,    // byte offered
    output wire       TX_READY,    // fifo can take byte
    output reg  [7:0] RX_DATA,     // received byte
    output reg        RX_VALID,    // one-cycle byte strobe
    output reg        RX_END,      // one-cycle frame end pulse
    output reg        RX_CRC_ERR,  // with RX_END, frame had error
    output reg        COLLISION,   // synced collision level, held low in rmii
    output reg        CARRIER,     // synced carrier level
    input  wire       MGMT_START,  // pulse, begin 32-bit shift
    input  wire [31:0] MGMT_WDATA, // word shifted out msb first
    output reg  [31:0] MGMT_RDATA, // bits captured on rising edges
    output wire       MGMT_BUSY,   // shift in progress
    output reg        MGMT_CLOCK_OUT, // management clock
    input  wire       MGMT_DATA_I, // management data in
    output reg        MGMT_DATA_O, // management data out
    output reg        MGMT_DATA_OE_N, // low while driving
    input  wire       TX_CLOCK_IN, // phy transmit clock
    input  wire       RX_CLOCK_IN, // phy rx clock or rmii ref clock
    input  wire [3:0] RX_NIBBLE,   // receive data pins
    input  wire       RX_VALID_IN, // rx valid or rmii carrier/valid
    input  wire       RX_ERROR_IN, // receive error
    input  wire       COLLISION_IN,// collision detect
    input  wire       CARRIER_SENSE_IN, // carrier sense
    output reg  [3:0] TX_NIBBLE,   // transmit data pins
    output reg        TX_ENABLE_OUT // tx enable or rmii tx enable
);
    // two-flop synchronisers, stage one read only by stage two
    reg [9:0] s1_q;
    reg [9:0] s2_q;
    reg       txc_d_q;
    reg       rxc_d_q;
    reg       mdi1_q;
    reg       mdi2_q;
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            s1_q <= 10'h000;
            s2_q <= 10'h000;
            txc_d_q <= 1'b0;
            rxc_d_q <= 1'b0;
            mdi1_q <= 1'b1;
            mdi2_q <= 1'b1;
        end else begin
            // management line returns from the phy pin, so it is synchronised too
            mdi1_q <= MGMT_DATA_I;
            mdi2_q <= mdi1_q;
            s1_q <= {TX_CLOCK_IN, RX_CLOCK_IN, RX_NIBBLE, RX_VALID_IN, RX_ERROR_IN,
                     COLLISION_IN, CARRIER_SENSE_IN};
            s2_q <= s1_q;
            txc_d_q <= s2_q[9];
            rxc_d_q <= s2_q[8];
        end
    end
    wire       txc_s = s2_q[9];
    wire       rxc_s = s2_q[8];
    wire [3:0] rxd_s = s2_q[7:4];
    wire       rxv_s = s2_q[3];
    wire       rxe_s = s2_q[2];
    wire       rx_rise = rxc_s && !rxc_d_q;
    // rmii: tx and rx both timed by the reference clock on the rx pin
    wire       tx_fall = MODE_RMII ? (!rxc_s && rxc_d_q) : (!txc_s && txc_d_q);

    // last unit index of a byte: four dibits or two nibbles
    function [1:0] last_step;
        input rmii;
        begin
            last_step = rmii ? 2'd3 : 2'd1;
        end
    endfunction

    // transmit path
    wire [8:0] f_data;
    wire       f_valid;
    reg        f_pop;
    epp_fifo #(.WIDTH(`EPP_FIFO_W), .DEPTH(`EPP_FIFO_D), .AW(`EPP_FIFO_AW)) u_fifo (
        .clk      (REF_CLK),
        .rst_n    (RESETN),
        .in_data  ({TX_LAST, TX_DATA}),
        .in_valid (TX_VALID),
        .in_ready (TX_READY),
        .out_data (f_data),
        .out_valid(f_valid),
        .out_ready(f_pop)
    );
    reg [8:0] tx_byte_q;
    reg       tx_have_q;
    reg [1:0] tx_pos_q;
    wire [1:0] tx_steps = last_step(MODE_RMII);
    // data changes on falling edge so the phy samples stable data on rising
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            tx_byte_q <= 9'h000;
            tx_have_q <= 1'b0;
            tx_pos_q <= 2'd0;
            TX_NIBBLE <= 4'h0;
            TX_ENABLE_OUT <= 1'b0;
            f_pop <= 1'b0;
        end else begin
            f_pop <= 1'b0;
            if (tx_fall) begin
                if (tx_have_q) begin
                    if (MODE_RMII)
                        TX_NIBBLE <= {2'b00, tx_byte_q[2*tx_pos_q +: 2]};
                    else
                        TX_NIBBLE <= tx_pos_q[0] ? tx_byte_q[7:4] : tx_byte_q[3:0];
                    TX_ENABLE_OUT <= 1'b1;
                    if (tx_pos_q == tx_steps) begin
                        tx_pos_q <= 2'd0;
                        tx_have_q <= 1'b0;
                    end else
                        tx_pos_q <= tx_pos_q + 2'd1;
                end else begin
                    // underrun or end of frame both drop enable
                    TX_NIBBLE <= 4'h0;
                    TX_ENABLE_OUT <= 1'b0;
                end
            end else if (!tx_have_q && f_valid && !f_pop &&
                         (!tx_byte_q[8] || !TX_ENABLE_OUT)) begin
                // after the last byte wait for enable to drop before next frame
                tx_byte_q <= f_data;
                tx_have_q <= 1'b1;
                f_pop <= 1'b1;
            end else if (!tx_have_q && tx_byte_q[8] && !TX_ENABLE_OUT)
                tx_byte_q[8] <= 1'b0;
        end
    end

    // receive path
    reg [7:0] rx_sh_q;
    reg [1:0] rx_pos_q;
    reg       rx_in_q;
    reg       rx_err_q;
    wire [1:0] rx_steps = last_step(MODE_RMII);
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            rx_sh_q <= 8'h00;
            rx_pos_q <= 2'd0;
            rx_in_q <= 1'b0;
            rx_err_q <= 1'b0;
            RX_DATA <= 8'h00;
            RX_VALID <= 1'b0;
            RX_END <= 1'b0;
            RX_CRC_ERR <= 1'b0;
            COLLISION <= 1'b0;
            CARRIER <= 1'b0;
        end else begin
            RX_VALID <= 1'b0;
            RX_END <= 1'b0;
            RX_CRC_ERR <= 1'b0;
            COLLISION <= MODE_RMII ? 1'b0 : s2_q[1];
            CARRIER <= MODE_RMII ? rxv_s : s2_q[0];
            if (rx_rise) begin
                if (rxv_s) begin
                    rx_in_q <= 1'b1;
                    if (rxe_s)
                        rx_err_q <= 1'b1;
                    if (MODE_RMII)
                        rx_sh_q <= {rxd_s[1:0], rx_sh_q[7:2]};
                    else
                        rx_sh_q <= {rxd_s, rx_sh_q[7:4]};
                    if (rx_pos_q == rx_steps) begin
                        rx_pos_q <= 2'd0;
                        RX_DATA <= MODE_RMII ? {rxd_s[1:0], rx_sh_q[7:2]}
                                             : {rxd_s, rx_sh_q[7:4]};
                        RX_VALID <= 1'b1;
                    end else
                        rx_pos_q <= rx_pos_q + 2'd1;
                end else if (rx_in_q) begin
                    // partial byte at frame end is discarded
                    rx_in_q <= 1'b0;
                    rx_pos_q <= 2'd0;
                    RX_END <= 1'b1;
                    RX_CRC_ERR <= rx_err_q || rxe_s;
                    rx_err_q <= 1'b0;
                end
            end
        end
    end

    // management shifter: one bit per mdc period, half period from ref clock
    reg [`EPP_MDC_CW-1:0]  mdc_cnt_q;
    reg [`EPP_MGMT_CW-1:0] mbit_q;
    reg [31:0]             msh_q;
    reg                    mbusy_q;
    assign MGMT_BUSY = mbusy_q;
    always @(posedge REF_CLK) begin
        if (!RESETN) begin
            mdc_cnt_q <= {`EPP_MDC_CW{1'b0}};
            mbit_q <= {`EPP_MGMT_CW{1'b0}};
            msh_q <= 32'h00000000;
            mbusy_q <= 1'b0;
            MGMT_RDATA <= 32'h00000000;
            MGMT_CLOCK_OUT <= 1'b0;
            MGMT_DATA_O <= 1'b0;
            MGMT_DATA_OE_N <= 1'b1;
        end else if (!mbusy_q) begin
            MGMT_CLOCK_OUT <= 1'b0;
            MGMT_DATA_OE_N <= 1'b1;
            if (MGMT_START) begin
                mbusy_q <= 1'b1;
                msh_q <= MGMT_WDATA;
                mbit_q <= {`EPP_MGMT_CW{1'b0}};
                mdc_cnt_q <= {`EPP_MDC_CW{1'b0}};
                MGMT_DATA_O <= MGMT_WDATA[31];
                MGMT_DATA_OE_N <= 1'b0;
            end
        end else if (mdc_cnt_q == `EPP_MDC_HALF - 1) begin
            mdc_cnt_q <= {`EPP_MDC_CW{1'b0}};
            MGMT_CLOCK_OUT <= !MGMT_CLOCK_OUT;
            if (!MGMT_CLOCK_OUT) begin
                // rising edge: capture the line
                MGMT_RDATA <= {MGMT_RDATA[30:0], mdi2_q};
            end else if (mbit_q == `EPP_MGMT_BITS - 1) begin
                mbusy_q <= 1'b0;
                MGMT_DATA_OE_N <= 1'b1;
            end else begin
                mbit_q <= mbit_q + 1'b1;
                msh_q <= {msh_q[30:0], 1'b0};
                MGMT_DATA_O <= msh_q[30];
            end
        end else
            mdc_cnt_q <= mdc_cnt_q + 1'b1;
    end
endmodule

/* File: epp_port_assertions.sv */
// concurrent checks on the pins of the ethernet port
`timescale 1ns/1ns
module epp_port_chk (
    input wire        REF_CLK,        // core clock
    input wire        RESETN,         // sync reset, active low
    input wire        MODE_RMII,      // 1 selects rmii
    input wire        MGMT_START,     // management start
    input wire [31:0] MGMT_WDATA,     // management word
    input wire        MGMT_BUSY,      // management busy
    input wire        MGMT_CLOCK_OUT, // management clock
    input wire        MGMT_DATA_O,    // management data out
    input wire        MGMT_DATA_OE_N, // low while driving
    input wire        RX_VALID,       // byte strobe
    input wire        RX_END,         // frame end
    input wire        RX_CRC_ERR,     // frame error
    input wire [3:0]  TX_NIBBLE,      // transmit pins
    input wire        TX_ENABLE_OUT   // transmit enable
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    a_mgmt_go: assert property (MGMT_START && !MGMT_BUSY |=> MGMT_BUSY)
        else $error("mgmt start not taken");
    a_mgmt_first: assert property ($rose(MGMT_BUSY) |->
        !MGMT_DATA_OE_N && MGMT_DATA_O == $past(MGMT_WDATA[31]))
        else $error("mgmt first bit wrong");
    a_mdc_idle: assert property (!MGMT_BUSY |-> !MGMT_CLOCK_OUT)
        else $error("mgmt clock runs while idle");
    a_mdc_half: assert property ($rose(MGMT_CLOCK_OUT) |->
        ##19 MGMT_CLOCK_OUT ##1 !MGMT_CLOCK_OUT)
        else $error("mgmt clock high time wrong");
    a_mdio_hold: assert property ($rose(MGMT_CLOCK_OUT) |-> $stable(MGMT_DATA_O))
        else $error("mgmt data moved at rising edge");
    a_oe_busy: assert property (MGMT_BUSY |-> !MGMT_DATA_OE_N)
        else $error("mgmt data released while busy");
    a_crc_end: assert property (RX_CRC_ERR |-> RX_END)
        else $error("crc flag without frame end");
    a_rx_pulse: assert property (RX_VALID |=> !RX_VALID)
        else $error("byte strobe too long");
    a_rmii_high: assert property (MODE_RMII && TX_ENABLE_OUT |-> TX_NIBBLE[3:2] == 2'b00)
        else $error("rmii upper lines driven");
    a_nib_stand: assert property ($changed(TX_NIBBLE) |=> $stable(TX_NIBBLE) [*6])
        else $error("transmit unit too short");
endmodule

bind epp_port epp_port_chk u_epp_port_chk (.REF_CLK, .RESETN, .MODE_RMII, .MGMT_START,
    .MGMT_WDATA, .MGMT_BUSY, .MGMT_CLOCK_OUT, .MGMT_DATA_O, .MGMT_DATA_OE_N,
    .RX_VALID, .RX_END, .RX_CRC_ERR, .TX_NIBBLE, .TX_ENABLE_OUT);

/* File: test_epp_port.sv */
// self-checking bench for the ethernet port
`timescale 1ns/1ns
module test_epp_port;
    logic REF_CLK = 0, RESETN = 0, MODE_RMII = 0, TX_LAST = 0, TX_VALID = 0, MGMT_START = 0;
    logic COLLISION_IN = 0, CARRIER_SENSE_IN = 0, full_seen = 0;
    logic [7:0] TX_DATA = 8'h00, RX_DATA;
    logic [31:0] MGMT_WDATA = 32'h0, MGMT_RDATA;
    logic [3:0] RX_NIBBLE, TX_NIBBLE;
    logic TX_READY, RX_VALID, RX_END, RX_CRC_ERR, COLLISION, CARRIER, MGMT_BUSY, MGMT_CLOCK_OUT;
    logic MGMT_DATA_O, MGMT_DATA_OE_N, TX_CLOCK_IN, RX_CLOCK_IN, RX_VALID_IN, RX_ERROR_IN;
    logic TX_ENABLE_OUT;
    wire MGMT_DATA_I = MGMT_DATA_OE_N ? 1'b1 : MGMT_DATA_O; // pull-up when released
    int bad_count = 0, checked = 0, cyc = 0;
    logic [31:0] rxq[$], txq[$], endq[$];
    always #5 REF_CLK = ~REF_CLK;
    epp_port u_epp_port (.REF_CLK, .RESETN, .MODE_RMII, .TX_DATA, .TX_LAST, .TX_VALID,
        .TX_READY, .RX_DATA, .RX_VALID, .RX_END, .RX_CRC_ERR, .COLLISION, .CARRIER,
        .MGMT_START, .MGMT_WDATA, .MGMT_RDATA, .MGMT_BUSY, .MGMT_CLOCK_OUT, .MGMT_DATA_I,
        .MGMT_DATA_O, .MGMT_DATA_OE_N, .TX_CLOCK_IN, .RX_CLOCK_IN, .RX_NIBBLE, .RX_VALID_IN,
        .RX_ERROR_IN, .COLLISION_IN, .CARRIER_SENSE_IN, .TX_NIBBLE, .TX_ENABLE_OUT);
    epp_phy_model u_epp_phy_model (.mode_rmii(MODE_RMII), .tx_clk(TX_CLOCK_IN),
        .rx_clk(RX_CLOCK_IN), .rxd(RX_NIBBLE), .rx_dv(RX_VALID_IN), .rx_er(RX_ERROR_IN));
    wire lclk = MODE_RMII ? RX_CLOCK_IN : TX_CLOCK_IN;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin bad_count++; $display("[ERR] %0t mismatch got %h exp %h", $time, s, e); end
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // units are seen at the link falling edge, before the device moves them
    // a unit with nothing expected is counted against an impossible value
    always @(negedge lclk)
        if (TX_ENABLE_OUT === 1'b1)
            chk(32'(TX_NIBBLE), txq.size() ? txq.pop_front() : 32'hffffffff);
    always @(posedge REF_CLK) begin
        if (RX_VALID) chk(32'(RX_DATA), rxq.size() ? rxq.pop_front() : 32'hffffffff);
        if (RX_END) chk(32'(RX_CRC_ERR), endq.size() ? endq.pop_front() : 32'hffffffff);
        cyc++;
        if (cyc == 60000) begin bad_count++; stop_test(); end
    end
    task automatic drain(input string name);
        for (int i = 0; i < 3000 && (txq.size() || rxq.size() || endq.size()); i++)
            @(posedge REF_CLK);
        repeat (20) @(posedge REF_CLK);
        chk(txq.size() + rxq.size() + endq.size(), 0);
        chk(32'(TX_ENABLE_OUT), 0);
        $display("test %s done", name);
    endtask
    task automatic tx_frame(input int n);
        logic [7:0] b;
        logic ok;
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (MODE_RMII) for (int k = 0; k < 8; k += 2) txq.push_back({30'h0, b[k+:2]});
            else begin txq.push_back(32'(b[3:0])); txq.push_back(32'(b[7:4])); end
            TX_DATA <= b; TX_LAST <= (i == n - 1); TX_VALID <= 1'b1;
            forever begin @(negedge REF_CLK); ok = TX_READY; full_seen |= !ok; @(posedge REF_CLK); if (ok) break; end
        end
        TX_VALID <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic rx_frame(input int n, input logic err);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            rxq.push_back(32'(b));
            u_epp_phy_model.send_byte(b, err && i == 1);
        end
        endq.push_back(32'(err));
        u_epp_phy_model.stop();
    endtask
    initial begin
        logic [31:0] w;
        void'($urandom(32'h5135f110));
        repeat (16) @(posedge REF_CLK);
        RESETN <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            @(posedge REF_CLK);
            MODE_RMII <= m[0];
            repeat (4) @(posedge REF_CLK);
            tx_frame(1); tx_frame(9); drain("tx");
            rx_frame(5, 1'b0); rx_frame(3, 1'b1); drain("rx");
        end
        chk(32'(full_seen), 1); // buffer refused while link drains
        // in rmii collision reads low and carrier follows the idle carrier/valid pin
        for (int i = 0; i < 8; i++) begin
            MODE_RMII <= i[2];
            COLLISION_IN <= i[0];
            CARRIER_SENSE_IN <= i[1];
            repeat (6) @(posedge REF_CLK);
            chk(32'(COLLISION), 32'(i[0] & !i[2]));
            chk(32'(CARRIER), 32'(i[1] & !i[2]));
        end
        w = $urandom;
        MGMT_WDATA <= w; MGMT_START <= 1'b1;
        @(posedge REF_CLK);
        MGMT_START <= 1'b0;
        @(posedge REF_CLK);
        for (int i = 0; i < 2000 && MGMT_BUSY !== 1'b0; i++) @(posedge REF_CLK);
        @(negedge REF_CLK);
        chk(MGMT_RDATA, w);
        chk(32'(MGMT_BUSY), 0);
        $display("test mgmt done");
        stop_test();
    end
endmodule
